// ### hdl/asrs_pkg.sv
// constants and types for the asynchronous serial receiver sampler
// assumes a 20 MHz core clock and an 8-bit register port
package asrs_pkg;
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FRAME_BITS = 10;
  // register offsets
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_DATA   = 2'h1;
  localparam logic [1:0] ADDR_CTL    = 2'h2;
  localparam logic [1:0] ADDR_BAUD   = 2'h3;
  // status bit positions
  localparam int unsigned ST_FULL_BIT = 0;
  localparam int unsigned ST_OVR_BIT  = 1;
  localparam int unsigned ST_NF_BIT   = 2;
  localparam int unsigned ST_FE_BIT   = 3;
  localparam int unsigned ST_IDLE_BIT = 4;
  localparam int unsigned ST_BUSY_BIT = 5;
  // serial_control_two bit positions
  localparam int unsigned CTL_SLEEP_BIT = 0;
  localparam int unsigned CTL_IWS_BIT   = 1;
  localparam int unsigned CTL_EN_BIT    = 2;
  // reset values
  localparam logic [7:0] CTL_RESET  = 8'h04;
  localparam logic [7:0] BAUD_RESET = 8'h0B;
  // sample slots
  localparam logic [4:0] SLOT_1  = 5'h01;
  localparam logic [4:0] SLOT_2  = 5'h02;
  localparam logic [4:0] SLOT_3  = 5'h03;
  localparam logic [4:0] SLOT_4  = 5'h04;
  localparam logic [4:0] SLOT_5  = 5'h05;
  localparam logic [4:0] SLOT_7  = 5'h07;
  localparam logic [4:0] SLOT_8  = 5'h08;
  localparam logic [4:0] SLOT_9  = 5'h09;
  localparam logic [4:0] SLOT_10 = 5'h0A;
  localparam logic [4:0] SLOT_13 = 5'h0D;
  localparam logic [4:0] SLOT_16 = 5'h10;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [7:0] IDLE_TICKS = 8'(OVERSAMPLE * FRAME_BITS);

  typedef enum logic [1:0] {
    ASRS_IDLE  = 2'b00,
    ASRS_START = 2'b01,
    ASRS_FRAME = 2'b10
  } asrs_state_t;

  typedef struct packed {
    logic       noise;
    logic [7:0] data;
  } asrs_char_t;
endpackage : asrs_pkg

// ### hdl/asrs_rx.sv
// asynchronous serial receiver: 16x sampler, character fifo, receive buffer and flags
// assumes rx_in and the register port are synchronous to core_clk
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module asrs_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = (AW+1)'(cnt_ff + {AW'(0), push} - {AW'(0), pop});
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
  // storage has no reset; only written entries are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule : asrs_fifo

module asrs_rx import asrs_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       rx_in,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);
  logic [7:0]  div_ff, nxt_div;
  logic        tick;
  asrs_state_t state_ff, nxt_state;
  logic [4:0]  rt_ff, nxt_rt;
  logic [3:0]  idx_ff, nxt_idx;
  logic [2:0]  hist_ff, nxt_hist;
  logic [2:0]  votes_ff, nxt_votes;
  logic [7:0]  shreg_ff, nxt_shreg;
  logic        nz_ff, nxt_nz;
  logic [7:0]  idle_cnt_ff, nxt_idle_cnt;
  logic        idle_arm_ff, nxt_idle_arm;
  logic        done, stop_ok, brk, idle_evt, edge_seen, bit_val, bit_end;
  logic [1:0]  zeros;
  logic [7:0]  ctl_ff, nxt_ctl, baud_ff, nxt_baud, data_ff, nxt_data, rdata_ff, nxt_rdata;
  logic        full_ff, nxt_full, ovr_ff, nxt_ovr, nf_ff, nxt_nf;
  logic        fe_ff, nxt_fe, idle_ff, nxt_idle, armed_ff, nxt_armed;
  logic        sleep, rx_en, push, ovr_evt, fe_evt, load, clr, f_in_ready, f_out_valid;
  asrs_char_t  f_in, f_out;
  assign sleep     = ctl_ff[CTL_SLEEP_BIT];
  assign rx_en     = ctl_ff[CTL_EN_BIT];
  assign reg_rdata = rdata_ff;
  // 16x tick every baud_ff+1 clocks; >= so a smaller divisor never waits for a wrap
  always_comb begin
    tick    = (div_ff >= baud_ff);
    nxt_div = tick ? 8'h00 : 8'(div_ff + 1'b1);
  end
  always_comb begin
    nxt_state    = state_ff;
    nxt_rt       = rt_ff;
    nxt_idx      = idx_ff;
    nxt_hist     = hist_ff;
    nxt_votes    = votes_ff;
    nxt_shreg    = shreg_ff;
    nxt_nz       = nz_ff;
    nxt_idle_cnt = idle_cnt_ff;
    nxt_idle_arm = idle_arm_ff;
    done         = 1'b0;
    idle_evt     = 1'b0;
    edge_seen    = (hist_ff == 3'h7) && !rx_in;
    zeros        = 2'(!votes_ff[1]) + 2'(!votes_ff[0]) + 2'(!rx_in);
    bit_val      = (zeros < 2'h2);
    bit_end      = 1'b0;
    stop_ok      = 1'b0;
    brk          = 1'b0;
    if (!rx_en) begin
      nxt_state = ASRS_IDLE;
      nxt_hist  = 3'h0;
    end else if (tick) begin
      nxt_hist = {hist_ff[1:0], rx_in};
      case (state_ff)
        ASRS_IDLE: begin
          if (rx_in) begin
            if (idle_cnt_ff == IDLE_TICKS) begin
              idle_evt     = idle_arm_ff;
              nxt_idle_arm = 1'b0;
            end else begin
              nxt_idle_cnt = 8'(idle_cnt_ff + 1'b1);
            end
          end else begin
            nxt_idle_cnt = 8'h00;
          end
          if (edge_seen) begin
            nxt_state = ASRS_START;
            nxt_rt    = SLOT_2;
            nxt_nz    = 1'b0;
            nxt_votes = 3'h0;
          end
        end
        ASRS_START: begin
          nxt_rt = 5'(rt_ff + 1'b1);
          if (rt_ff == SLOT_3 || rt_ff == SLOT_5 || rt_ff == SLOT_7 ||
              rt_ff == SLOT_8 || rt_ff == SLOT_9 || rt_ff == SLOT_10) begin
            nxt_votes = {votes_ff[1:0], rx_in};
            nxt_nz    = nz_ff | rx_in;
          end
          // only slots 3,5,7 decide the start bit; later highs are noise only
          if (rt_ff == SLOT_7 && !bit_val == 1'b0) begin
            nxt_state = ASRS_IDLE;
            nxt_hist  = 3'h0;
          end
          if (rt_ff == SLOT_16) begin
            nxt_state = ASRS_FRAME;
            nxt_idx   = 4'h1;
            nxt_rt    = SLOT_1;
          end
        end
        ASRS_FRAME: begin
          if (rt_ff == SLOT_8 || rt_ff == SLOT_9) begin
            nxt_votes = {votes_ff[1:0], rx_in};
          end
          bit_end = (rt_ff == SLOT_16) || (edge_seen && rt_ff >= SLOT_13);
          if (rt_ff == SLOT_10) begin
            nxt_nz = nz_ff | (zeros != 2'h0 && zeros != 2'h3);
            if (idx_ff != STOP_IDX) begin
              nxt_shreg = {bit_val, shreg_ff[7:1]};
            end else begin
              done         = 1'b1;
              stop_ok      = bit_val;
              brk          = !bit_val && (shreg_ff == 8'h00);
              nxt_state    = ASRS_IDLE;
              nxt_hist     = brk ? 3'h0 : 3'h7;
              nxt_idle_cnt = 8'h00;
              nxt_idle_arm = 1'b1;
            end
          end
          if (rt_ff != SLOT_10 || idx_ff != STOP_IDX) begin
            if (bit_end) begin
              nxt_idx = 4'(idx_ff + 1'b1);
              nxt_rt  = edge_seen ? SLOT_2 : SLOT_1;
            end else if (edge_seen && rt_ff <= SLOT_4) begin
              nxt_rt = SLOT_2;
            end else begin
              nxt_rt = 5'(rt_ff + 1'b1);
            end
          end
        end
        default: begin
          nxt_state = ASRS_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff      <= 8'h00;
      state_ff    <= ASRS_IDLE;
      rt_ff       <= SLOT_1;
      idx_ff      <= 4'h0;
      hist_ff     <= 3'h0;
      votes_ff    <= 3'h0;
      shreg_ff    <= 8'h00;
      nz_ff       <= 1'b0;
      idle_cnt_ff <= 8'h00;
      idle_arm_ff <= 1'b0;
    end else begin
      div_ff      <= nxt_div;
      state_ff    <= nxt_state;
      rt_ff       <= nxt_rt;
      idx_ff      <= nxt_idx;
      hist_ff     <= nxt_hist;
      votes_ff    <= nxt_votes;
      shreg_ff    <= nxt_shreg;
      nz_ff       <= nxt_nz;
      idle_cnt_ff <= nxt_idle_cnt;
      idle_arm_ff <= nxt_idle_arm;
    end
  end
  // fifo sits between the shifter and the buffer; its fill level is the overrun margin
  asrs_fifo #(
    .WIDTH ($bits(asrs_char_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (f_in),
    .out_valid (f_out_valid),
    .out_ready (!full_ff),
    .out_data  (f_out)
  );
  always_comb begin
    f_in.noise = nz_ff;
    f_in.data  = shreg_ff;
    ovr_evt    = done && !sleep && !fe_ff && !f_in_ready;
    push       = done && !sleep && !fe_ff && f_in_ready;
    fe_evt     = done && !sleep && !stop_ok;
    load       = f_out_valid && !full_ff;
    clr        = reg_rd && (reg_addr == ADDR_DATA) && armed_ff;
    nxt_armed  = armed_ff;
    if (reg_rd && reg_addr == ADDR_STATUS) begin
      nxt_armed = full_ff | ovr_ff | fe_ff | idle_ff;
    end else if (reg_rd && reg_addr == ADDR_DATA) begin
      nxt_armed = 1'b0;
    end
    // hardware sets win over the software clear
    nxt_full = load | (full_ff & ~clr);
    nxt_ovr  = ovr_evt | (ovr_ff & ~clr);
    nxt_nf   = (load & f_out.noise) | (nf_ff & ~clr);
    nxt_fe   = fe_evt | (fe_ff & ~clr);
    nxt_idle = (idle_evt & (!sleep | ctl_ff[CTL_IWS_BIT])) | (idle_ff & ~clr);
    nxt_data = load ? f_out.data : data_ff;
    nxt_ctl  = ctl_ff;
    nxt_baud = baud_ff;
    if (reg_wr && reg_addr == ADDR_CTL) begin
      nxt_ctl = reg_wdata & 8'h07;
    end else if (idle_evt && ctl_ff[CTL_IWS_BIT]) begin
      nxt_ctl[CTL_SLEEP_BIT] = 1'b0;
    end
    if (reg_wr && reg_addr == ADDR_BAUD) begin
      nxt_baud = reg_wdata;
    end
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: begin
          nxt_rdata[ST_FULL_BIT] = full_ff;
          nxt_rdata[ST_OVR_BIT]  = ovr_ff;
          nxt_rdata[ST_NF_BIT]   = nf_ff;
          nxt_rdata[ST_FE_BIT]   = fe_ff;
          nxt_rdata[ST_IDLE_BIT] = idle_ff;
          nxt_rdata[ST_BUSY_BIT] = (state_ff != ASRS_IDLE);
        end
        ADDR_DATA: nxt_rdata = data_ff;
        ADDR_CTL:  nxt_rdata = ctl_ff;
        ADDR_BAUD: nxt_rdata = baud_ff;
        default:   nxt_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      full_ff  <= 1'b0;
      ovr_ff   <= 1'b0;
      nf_ff    <= 1'b0;
      fe_ff    <= 1'b0;
      idle_ff  <= 1'b0;
      armed_ff <= 1'b0;
      data_ff  <= 8'h00;
      ctl_ff   <= CTL_RESET;
      baud_ff  <= BAUD_RESET;
      rdata_ff <= 8'h00;
    end else begin
      full_ff  <= nxt_full;
      ovr_ff   <= nxt_ovr;
      nf_ff    <= nxt_nf;
      fe_ff    <= nxt_fe;
      idle_ff  <= nxt_idle;
      armed_ff <= nxt_armed;
      data_ff  <= nxt_data;
      ctl_ff   <= nxt_ctl;
      baud_ff  <= nxt_baud;
      rdata_ff <= nxt_rdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_overrun_set: assert property (ovr_evt |=> ovr_ff)
    else $error("overrun event did not set flag");
  a_buffer_hold: assert property (full_ff && !clr |=> $stable(data_ff) && full_ff)
    else $error("buffer changed while full");
  a_clear_seq: assert property (clr && !f_out_valid && !push |=> !full_ff ##1 !full_ff)
    else $error("full flag survived clear sequence");
  a_edge_start: assert property (rx_en && tick && state_ff == ASRS_IDLE && hist_ff == 3'h7
      && !rx_in |=> state_ff == ASRS_START && rt_ff == SLOT_2)
    else $error("falling edge not taken");
  a_false_start: assert property (rx_en && tick && state_ff == ASRS_START && rt_ff == SLOT_7
      && zeros < 2'h2 |=> state_ff == ASRS_IDLE)
    else $error("noise accepted as start");
  a_noise_load: assert property (load && f_out.noise |=> nf_ff)
    else $error("noise flag missed on transfer");
  a_fe_block: assert property (fe_ff && done |-> !push ##1 $stable(full_ff) || !full_ff)
    else $error("character moved with framing flag set");
  a_sleep_quiet: assert property (sleep && done |-> !push && !ovr_evt && !fe_evt)
    else $error("flags raised while asleep");
  a_stop_frame: assert property (done && !stop_ok && !sleep |=> fe_ff)
    else $error("low stop bit without framing flag");
  a_hist_preload: assert property (done && !stop_ok && !brk |=> hist_ff == 3'h7)
    else $error("edge history not preloaded");
  c_good_char: cover property (load && !f_out.noise);
  c_overrun:   cover property (ovr_evt);
  c_resync:    cover property (tick && state_ff == ASRS_FRAME && edge_seen);
  c_idle_wake: cover property (idle_evt && sleep && ctl_ff[CTL_IWS_BIT]);
endmodule : asrs_rx

// ### verif/asrs_tx_model.sv
// behavioural sender standing on the receive line of the sampler
// assumes the line idles high and changes only after rising clock edges
`timescale 1ns/100ps

module asrs_tx_model (
  input  wire logic core_clk,
  output logic      rx_line
);
  initial rx_line = 1'b1;

  // per clocks per bit; gl slots from slot gs of bit gb inverted, gb < 0 is clean
  task automatic send(input logic [7:0] d, input logic stp, input int per,
                      input int gb, input int gs, input int gl);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      for (int s = 1; s <= per; s++) begin
        @(posedge core_clk);
        rx_line <= f[b] ^ (b == gb && s >= gs && s < gs + gl);
      end
    end
  endtask : send

  task automatic hold(input logic lvl, input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_line <= lvl;
    end
  endtask : hold
endmodule : asrs_tx_model

// ### verif/tb.sv
// self-checking bench for the serial receiver: register port master plus serial sender
// assumes baud register 0 gives one sample tick per core clock, 16 clocks per bit
`timescale 1ns/100ps

module tb;
  import asrs_pkg::*;
  logic        core_clk;
  logic        nrst;
  logic        rx_in;
  logic        reg_wr;
  logic        reg_rd;
  logic        rd_d;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  v;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [16:0] notes[$];
  logic [7:0]  sent[$];
  int          num_errors = 0;
  int          check_count = 0;

  asrs_rx i_asrs_rx (.core_clk(core_clk), .nrst(nrst), .rx_in(rx_in), .reg_addr(reg_addr),
                     .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                     .reg_rdata(reg_rdata));
  asrs_tx_model u_tx (.core_clk(core_clk), .rx_line(rx_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) begin
    logic [16:0] n;
    if (rd_d === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      if (n[16]) check("read data", reg_rdata & n[15:8], n[7:0]);
    end
  end

  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // c low: poll only, value left in v
  task automatic rd(input logic [1:0] ad, input logic c, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    notes.push_back({c, m, e & m});
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd

  task automatic wait_full();
    for (int i = 0; i < 300; i++) begin
      rd(ADDR_STATUS, 1'b0, 8'h00, 8'h00);
      if (v[ST_FULL_BIT] === 1'b1) return;
    end
    check("full flag wait", 8'h00, 8'h01);
  endtask : wait_full

  // status then data read: also the clearing sequence
  task automatic recv(input logic [7:0] m, input logic [7:0] st, input logic [7:0] d);
    wait_full();
    rd(ADDR_STATUS, 1'b1, m, st);
    rd(ADDR_DATA, 1'b1, 8'hFF, d);
  endtask : recv

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial begin
    #(50 * 40000);
    num_errors++;
    complete_run();
  end

  initial begin
    nrst      = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 2'h0;
    reg_wdata = 8'h00;
    v = 8'($urandom(13552));
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(ADDR_CTL, 1'b1, 8'hFF, CTL_RESET);
    rd(ADDR_BAUD, 1'b1, 8'hFF, BAUD_RESET);
    wr(ADDR_STATUS, 8'hFF);
    wr(ADDR_DATA, 8'h5A);
    wr(ADDR_CTL, 8'hFF);
    rd(ADDR_STATUS, 1'b1, 8'hFF, 8'h00);
    rd(ADDR_DATA, 1'b1, 8'hFF, 8'h00);
    rd(ADDR_CTL, 1'b1, 8'hFF, 8'h07);
    wr(ADDR_CTL, CTL_RESET);
    wr(ADDR_BAUD, 8'h00);
    rd(ADDR_BAUD, 1'b1, 8'hFF, 8'h00);
    // two frames back to back, second shifts in while first waits
    a = 8'($urandom);
    b = 8'($urandom);
    u_tx.send(a, 1'b1, 16, -1, 0, 0);
    u_tx.send(b, 1'b1, 16, -1, 0, 0);
    recv(8'h0F, 8'h01, a);
    recv(8'h0F, 8'h01, b);
    rd(ADDR_STATUS, 1'b1, 8'h0F, 8'h00);
    // single odd sample in a data bit, then high samples inside the start bit
    u_tx.send(a, 1'b1, 16, 3, 9, 1);
    recv(8'h0F, 8'h05, a);
    u_tx.send(b, 1'b1, 16, 0, 8, 2);
    recv(8'h0F, 8'h05, b);
    rd(ADDR_STATUS, 1'b1, 8'h0F, 8'h00);
    // short low pulse is no start bit
    u_tx.hold(1'b0, 2);
    u_tx.hold(1'b1, 220);
    rd(ADDR_STATUS, 1'b1, 8'h0F, 8'h00);
    // receiver disabled: a whole frame leaves no trace
    wr(ADDR_CTL, 8'h00);
    u_tx.send(a, 1'b1, 16, -1, 0, 0);
    rd(ADDR_STATUS, 1'b1, 8'h0F, 8'h00);
    wr(ADDR_CTL, CTL_RESET);
    // history restarts empty; give it three high samples before the next start
    u_tx.hold(1'b1, 4);
    // sender slow and fast by one clock per bit; edges realign sampling
    for (int p = 15; p <= 17; p += 2) begin
      u_tx.send(8'h55, 1'b1, p, -1, 0, 0);
      recv(8'h0B, 8'h01, 8'h55);
    end
    // fill fifo and buffer until a frame is refused, then drain in order
    for (int i = 0; i < 34; i++) begin
      sent.push_back(8'($urandom));
      u_tx.send(sent[i], 1'b1, 16, -1, 0, 0);
    end
    for (int i = 0; i < 33; i++) recv(8'h0F, (i == 0) ? 8'h03 : 8'h01, sent[i]);
    rd(ADDR_STATUS, 1'b1, 8'h0F, 8'h00);
    // low stop bit with the next start right behind it
    for (int k = 0; k < 2; k++) begin
      a = 8'($urandom) | 8'h01;
      b = 8'($urandom);
      fork
        begin
          u_tx.send(a, 1'b0, 16, -1, 0, 0);
          u_tx.send(b, 1'b1, 16, -1, 0, 0);
          u_tx.hold(1'b1, 4);
        end
      join_none
      if (k == 1) wait fork;
      recv(8'h0F, 8'h09, a);
      if (k == 0) recv(8'h0F, 8'h01, b);
      else rd(ADDR_STATUS, 1'b1, 8'h0F, 8'h00);
      // the sender must be idle before the next pass drives the line again
      wait fork;
    end
    // clear any idle flag, then sleep without and with idle wake
    u_tx.hold(1'b1, 200);
    rd(ADDR_STATUS, 1'b0, 8'h00, 8'h00);
    rd(ADDR_DATA, 1'b0, 8'h00, 8'h00);
    rd(ADDR_STATUS, 1'b1, 8'h1F, 8'h00);
    wr(ADDR_CTL, 8'h05);
    u_tx.send(a, 1'b0, 16, 3, 9, 1);
    u_tx.hold(1'b1, 200);
    rd(ADDR_STATUS, 1'b1, 8'h1F, 8'h00);
    wr(ADDR_CTL, 8'h07);
    u_tx.send(b, 1'b1, 16, -1, 0, 0);
    u_tx.hold(1'b1, 200);
    rd(ADDR_STATUS, 1'b1, 8'h1F, 8'h10);
    rd(ADDR_CTL, 1'b1, 8'hFF, 8'h06);
    complete_run();
  end
endmodule : tb
